// ---- rtl/gptg_defs.vh ----
// Constants for the gated pulse train generator: register offsets, fields, reset values.
// Assumes a 32-bit APB register bus with byte addresses, one aligned word per register.
`ifndef GPTG_DEFS_VH
`define GPTG_DEFS_VH

// Register byte offsets
`define GPTG_CTRL_OFS        8'h00
`define GPTG_TIMEBASE_OFS    8'h04
`define GPTG_PERIOD_OFS      8'h08
`define GPTG_DUTY_OFS        8'h0C
`define GPTG_ACT_PERIOD_OFS  8'h10
`define GPTG_ACT_PHASE2_OFS  8'h14
`define GPTG_STATUS_OFS      8'h18

// Control register fields
`define GPTG_CTRL_START_BIT  0
`define GPTG_CTRL_GATE_LSB   1
`define GPTG_CTRL_GATE_MSB   3
`define GPTG_CTRL_POL_BIT    4

// Gate mode codes
`define GPTG_GATE_NONE       3'h0
`define GPTG_GATE_HIGH       3'h1
`define GPTG_GATE_LOW        3'h2
`define GPTG_GATE_RISE       3'h3
`define GPTG_GATE_FALL       3'h4

// Timebase values that select the internal clock
`define GPTG_TB_INT_ZERO     32'h00000000
`define GPTG_TB_INT_10MHZ    32'h00989680

// Duty cycle is an unsigned fraction with 16 fraction bits
`define GPTG_DUTY_FRAC_W     16
`define GPTG_DUTY_HALF       16'h8000

// Reset values
`define GPTG_CTRL_RST        32'h00000000
`define GPTG_TIMEBASE_RST    32'h00000000
`define GPTG_PERIOD_RST      32'h0000000A

// Shortest period in timebase cycles
`define GPTG_MIN_PERIOD      32'h00000003

`endif

// ---- rtl/gptg_top.v ----
// Gated pulse train generator with APB register access.
// Assumes pclk is the 10 MHz internal timebase; ext_timebase_in and the gate come from pins.
`include "gptg_defs.vh"
`default_nettype none

// Contract
// - Drive a continuous pulse train on the output once configured and started.
// - Waveform repeats each period: first (delay) phase then second phase.
// - Duty sets second phase as fraction of period; default one half.
// - Period at least three cycles; duty 0 or 1 clamped to nearest achievable.
// - Timebase 0 or 10000000 selects internal 10 MHz clock, else external input.
// - Gate mode 0 ignores gate and runs from start command; default mode.
// - Gate mode 1 runs while gate high, mode 2 while gate low.
// - Gate mode 3 starts on gate rising edge, mode 4 on falling edge.
// - Modes 3 and 4 emit one pulse per qualifying gate edge that arrives while no pulse is running.
// - Polarity 0: low in first phase, high in second; default.
// - Polarity 1: high in first phase, low in second.
// - Achieved period and second-phase length are readable by software.
module gptg_top #(
    parameter CNT_W = 32
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ext_timebase_in,
    input  wire        counter_gate_input,
    output reg         counter_pulse_output
);

    localparam DW = `GPTG_DUTY_FRAC_W;

    // Software-visible registers
    reg [31:0]      ctrl_reg;
    reg [31:0]      timebase_reg;
    reg [CNT_W-1:0] period_reg;
    reg [DW-1:0]    duty_reg;
    reg [CNT_W-1:0] act_period_reg;
    reg [CNT_W-1:0] act_phase2_reg;

    // Pin synchronisers
    reg             ext_s1_reg;
    reg             ext_s2_reg;
    reg             ext_d_reg;
    reg             gate_s1_reg;
    reg             gate_s2_reg;
    reg             gate_d_reg;

    // Counter state
    reg [CNT_W-1:0] cnt_reg;
    reg             single_busy_reg;

    wire            start_bit = ctrl_reg[`GPTG_CTRL_START_BIT];
    wire [2:0]      gate_mode = ctrl_reg[`GPTG_CTRL_GATE_MSB:`GPTG_CTRL_GATE_LSB];
    wire            polarity  = ctrl_reg[`GPTG_CTRL_POL_BIT];

    // Internal timebase ticks every pclk; external counts synchronised rising edges
    wire use_internal = (timebase_reg == `GPTG_TB_INT_ZERO) || (timebase_reg == `GPTG_TB_INT_10MHZ);
    wire ext_rise     = ext_s2_reg & ~ext_d_reg;
    wire tick         = use_internal ? 1'b1 : ext_rise;

    wire gate_rise = gate_s2_reg & ~gate_d_reg;
    wire gate_fall = ~gate_s2_reg & gate_d_reg;

    // Effective period and second phase from the requested values
    reg [CNT_W-1:0]    per_eff;
    reg [CNT_W+DW-1:0] prod;
    reg [CNT_W-1:0]    ph2_eff;

    always @* begin
        per_eff = period_reg;
        if (period_reg < `GPTG_MIN_PERIOD) begin
            per_eff = `GPTG_MIN_PERIOD;
        end
        prod    = per_eff * duty_reg;
        ph2_eff = prod[CNT_W+DW-1:DW];
        if (ph2_eff == {CNT_W{1'b0}}) begin
            ph2_eff = {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (ph2_eff >= per_eff) begin
            ph2_eff = per_eff - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Whether the counter may advance on this tick
    reg run_en;
    always @* begin
        run_en = 1'b0;
        if (start_bit) begin
            case (gate_mode)
                `GPTG_GATE_NONE: run_en = 1'b1;
                `GPTG_GATE_HIGH: run_en = gate_s2_reg;
                `GPTG_GATE_LOW:  run_en = ~gate_s2_reg;
                `GPTG_GATE_RISE: run_en = single_busy_reg;
                `GPTG_GATE_FALL: run_en = single_busy_reg;
                default:         run_en = 1'b0;
            endcase
        end
    end

    wire edge_mode = (gate_mode == `GPTG_GATE_RISE) || (gate_mode == `GPTG_GATE_FALL);
    wire trig      = start_bit && !single_busy_reg &&
                     (((gate_mode == `GPTG_GATE_RISE) && gate_rise) ||
                      ((gate_mode == `GPTG_GATE_FALL) && gate_fall));
    wire last_cnt  = (cnt_reg == act_period_reg - {{(CNT_W-1){1'b0}}, 1'b1});
    wire in_phase2 = (cnt_reg >= act_period_reg - act_phase2_reg);

    // Pin synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_reg  <= 1'b0;
            ext_s2_reg  <= 1'b0;
            ext_d_reg   <= 1'b0;
            gate_s1_reg <= 1'b0;
            gate_s2_reg <= 1'b0;
            gate_d_reg  <= 1'b0;
        end else begin
            ext_s1_reg  <= ext_timebase_in;
            ext_s2_reg  <= ext_s1_reg;
            ext_d_reg   <= ext_s2_reg;
            gate_s1_reg <= counter_gate_input;
            gate_s2_reg <= gate_s1_reg;
            gate_d_reg  <= gate_s2_reg;
        end
    end

    // Period counter; settings take effect at a period boundary so no phase is cut short
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg         <= {CNT_W{1'b0}};
            single_busy_reg <= 1'b0;
            act_period_reg  <= `GPTG_PERIOD_RST;
            act_phase2_reg  <= `GPTG_PERIOD_RST >> 1;
        end else begin
            if (!start_bit) begin
                cnt_reg         <= {CNT_W{1'b0}};
                single_busy_reg <= 1'b0;
                act_period_reg  <= per_eff;
                act_phase2_reg  <= ph2_eff;
            end else if (trig) begin
                single_busy_reg <= 1'b1;
                cnt_reg         <= {CNT_W{1'b0}};
                act_period_reg  <= per_eff;
                act_phase2_reg  <= ph2_eff;
            end else if (run_en && tick) begin
                if (last_cnt) begin
                    cnt_reg        <= {CNT_W{1'b0}};
                    act_period_reg <= per_eff;
                    act_phase2_reg <= ph2_eff;
                    if (edge_mode) begin
                        single_busy_reg <= 1'b0;
                    end
                end else begin
                    cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Output level: second phase shown while started, also if gated modes 1/2 pause the counter; in modes 3 and 4 only while busy
    wire active_ph2 = start_bit && (edge_mode ? single_busy_reg : 1'b1) && in_phase2;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_pulse_output <= 1'b0;
        end else if (polarity) begin
            counter_pulse_output <= ~active_ph2;
        end else begin
            counter_pulse_output <= active_ph2;
        end
    end

    // APB slave: no wait states, answer in the cycle after setup
    wire setup_ph  = psel && !penable;
    wire access_ok = psel && penable && pready;
    wire wr_en     = access_ok && pwrite && !pslverr;

    reg        addr_hit;
    reg [31:0] rd_mux;
    always @* begin
        addr_hit = 1'b1;
        rd_mux   = 32'h00000000;
        case (paddr)
            `GPTG_CTRL_OFS:       rd_mux = ctrl_reg;
            `GPTG_TIMEBASE_OFS:   rd_mux = timebase_reg;
            `GPTG_PERIOD_OFS:     rd_mux = period_reg;
            `GPTG_DUTY_OFS:       rd_mux = {{(32-DW){1'b0}}, duty_reg};
            `GPTG_ACT_PERIOD_OFS: rd_mux = act_period_reg;
            `GPTG_ACT_PHASE2_OFS: rd_mux = act_phase2_reg;
            `GPTG_STATUS_OFS:     rd_mux = {28'h0000000, in_phase2, single_busy_reg, run_en, counter_pulse_output};
            default:              addr_hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && !addr_hit;
            if (setup_ph && !pwrite) begin
                prdata <= rd_mux;
            end else if (access_ok) begin
                prdata <= 32'h00000000;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= `GPTG_CTRL_RST;
            timebase_reg <= `GPTG_TIMEBASE_RST;
            period_reg   <= `GPTG_PERIOD_RST;
            duty_reg     <= `GPTG_DUTY_HALF;
        end else if (wr_en) begin
            case (paddr)
                `GPTG_CTRL_OFS:     ctrl_reg     <= {27'h0000000, pwdata[4:0]};
                `GPTG_TIMEBASE_OFS: timebase_reg <= pwdata;
                `GPTG_PERIOD_OFS:   period_reg   <= pwdata[CNT_W-1:0];
                `GPTG_DUTY_OFS:     duty_reg     <= pwdata[DW-1:0];
                default:            ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- tb/gptg_monitor.sv ----
// Port checker for gptg_top: APB answer timing, error replies, readback bounds.
// Bound to the top from tb; single clock domain.
`default_nettype none
module gptg_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        counter_pulse_output
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_late: assert property (psel && !penable |=> pready) else $error("late ready");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held");
    a_ready_sel: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_hole: assert property (psel && !penable && (paddr > 8'h18 || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("no error");
    a_err_none: assert property (psel && !penable && paddr < 8'h19 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("bad error");
    a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
    a_act_period: assert property (pready && !pwrite && paddr == 8'h10 |-> prdata > 32'h2) else $error("period");
    a_act_phase: assert property (pready && !pwrite && paddr == 8'h14 |-> prdata > 32'h0) else $error("phase");
    c_err: cover property (pslverr);
    c_rise: cover property ($rose(counter_pulse_output));
    c_act: cover property (pready && paddr == 8'h14);
endmodule
`default_nettype wire

// ---- tb/gptg_far.sv ----
// Far-side model: gate level requested by tb, free external timebase at pclk/4.
// Assumes pclk from tb.
`default_nettype none
module gptg_far (
    input  wire logic pclk,
    input  wire logic gate_req,
    output var  logic gate,
    output var  logic ext_tb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_reg = 2'h0;
    always @(posedge pclk) div_reg <= div_reg + 2'h1;
    assign gate = gate_req;
    assign ext_tb = div_reg[1];
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for gptg_top: APB master, integer model of achieved counts, pulse timing.
// Uses gptg_far on the pin side and binds gptg_monitor.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gate_req = 1'b0;
    logic        pready, pslverr, gate, ext_tb, out, er, pl;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          num_errors, n_tests, ap, a2, i, n, n0;
    gptg_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_timebase_in(ext_tb), .counter_gate_input(gate), .counter_pulse_output(out));
    gptg_far i_far (.pclk(pclk), .gate_req(gate_req), .gate(gate), .ext_tb(ext_tb));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        n_tests++;
        num_errors += (v !== e);
        if (v !== e) $display("MISMATCH %s expected %h seen %h", s, e, v);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic cfg(input logic [31:0] t, input int p, input logic [15:0] d, input int m, input logic g, q);
        pl = q;
        apb(1'b1, 8'h00, 32'h0);
        gate_req <= g;
        apb(1'b1, 8'h04, t);
        apb(1'b1, 8'h08, 32'(p));
        apb(1'b1, 8'h0C, {16'h0, d});
        apb(1'b1, 8'h00, {27'h0, pl, m[2:0], 1'b1});
        ap = p < 3 ? 3 : p;
        a2 = (ap * d) >> 16;
        a2 = a2 < 1 ? 1 : a2 >= ap ? ap - 1 : a2;
    endtask
    task automatic meas(input int k);
        int h, l;
        while (out !== pl) @(posedge pclk);
        while (out === pl) @(posedge pclk);
        for (h = 0; out === ~pl; h++) @(posedge pclk);
        for (l = 0; out === pl; l++) @(posedge pclk);
        chk("phase2", a2 * k, h);
        chk("phase1", (ap - a2) * k, l);
        apb(1'b0, 8'h10, 32'h0);
        chk("act_period", ap, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("act_phase2", a2, rd);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #50 pclk = ~pclk;
    always @(out) n++;
    initial begin
        #2000000 num_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'hF7EF124F));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        chk("err_data", 32'h0, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("duty_rst", 32'h8000, rd);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_rst", 32'h0, rd);
        for (i = 0; i < 11; i++) begin
            cfg(i == 4 ? 32'h5 : i[1] ? 32'h989680 : 32'h0,
                i > 6 ? 3 + $urandom % 38 : i > 4 ? i - 5 : 10,
                i > 6 ? 16'($urandom) : i == 5 ? 16'h0 : i == 6 ? 16'hFFFF : 16'h8000,
                0, 0, i > 6 ? 1'($urandom) : i[0]);
            meas(i == 4 ? 4 : 1);
        end
        for (i = 1; i < 5; i++) begin
            cfg(32'h0, 10, 16'h8000, i, i == 2 || i == 4, 1'b0);
            n0 = n;
            repeat (40) @(posedge pclk);
            chk("held", 32'h0, n - n0);
            gate_req <= i == 1 || i == 3;
            n0 = n;
            if (i < 3) meas(1);
            else repeat (60) @(posedge pclk);
            if (i > 2) chk("one_pulse", 32'h2, n - n0);
        end
        report_and_stop;
    end
endmodule
bind gptg_top gptg_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_pulse_output(counter_pulse_output));
`default_nettype wire
